//--- rtl/hpw_pkg.sv
// Shared constants for the host write port link
// Functional notes
// RULE_01 - Every host write uses one cycle protocol
// RULE_02 - Either strobe may frame the cycle
// RULE_03 - Cycle starts when both strobes low
// RULE_04 - Cycle ends when either strobe rises
// RULE_05 - Strobe high at least 13 ns between
// RULE_06 - Strobes jointly low at least 32 ns
// RULE_07 - Whole write cycle at least 165 ns
// RULE_08 - Sixteen bit data, one word per cycle
// RULE_09 - Queue select pushes word, skips upper decode
// RULE_10 - Queue writes use identical cycle protocol
// RULE_11 - Queue select sampled like an address line
// RULE_12 - Queue mode keeps A[2:1], ignores A[7:3]
// RULE_13 - Capture and push at cycle ending edge
package hpw_pkg;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 7;
  localparam int LANE_W = 2;
  localparam int FIFO_DEPTH = 8;
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_CYCLE_NS = 165;
  localparam int T_CSL_NS = 32;
  localparam int T_CSH_NS = 13;
  localparam int CYCLE_CYC_RAW = (T_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSL_CYC_RAW = (T_CSL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CSH_CYC_RAW = (T_CSH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CYCLE_CYC = (CYCLE_CYC_RAW < 1) ? 1 : CYCLE_CYC_RAW;
  localparam int CSL_CYC = (CSL_CYC_RAW < 1) ? 1 : CSL_CYC_RAW;
  localparam int CSH_CYC = (CSH_CYC_RAW < 1) ? 1 : CSH_CYC_RAW;
  localparam int ASSERT_CYC = (CSL_CYC > CYCLE_CYC - CSH_CYC) ? CSL_CYC : CYCLE_CYC - CSH_CYC;
  localparam int RELEASE_CYC = (CSH_CYC > CYCLE_CYC - ASSERT_CYC) ? CSH_CYC : CYCLE_CYC - ASSERT_CYC;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] ASSERT_LAST = CNT_W'(ASSERT_CYC - 1);
  localparam logic [CNT_W-1:0] RELEASE_LAST = CNT_W'(RELEASE_CYC - 1);
  localparam logic STROBE_IDLE = 1'b1;
  localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RST = 7'h00;
  localparam int SYNC_W = 3 + ADDR_W + DATA_W;
endpackage

//--- rtl/hpw_link_if.sv
// Write link between host and device ends
`timescale 1ns/100ps
interface hpw_link_if;
  logic chip_sel_low;
  logic write_strobe_low;
  logic [hpw_pkg::ADDR_W-1:0] addr;
  logic fifo_sel;
  logic [hpw_pkg::DATA_W-1:0] data;
  modport host (
    output chip_sel_low,
    output write_strobe_low,
    output addr,
    output fifo_sel,
    output data
  );
  modport dev (
    input chip_sel_low,
    input write_strobe_low,
    input addr,
    input fifo_sel,
    input data
  );
endinterface

//--- rtl/hpw_host.sv
// Host end: drives programmed write cycles onto the link
`timescale 1ns/100ps
module hpw_host (
  input wire logic core_clk,
  input wire logic rst,
  hpw_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [hpw_pkg::ADDR_W-1:0] req_addr,
  input wire logic req_fifo,
  input wire logic [hpw_pkg::DATA_W-1:0] req_data,
  input wire logic frame_by_cs
);
  typedef enum logic [1:0] {HPW_IDLE, HPW_ASSERT, HPW_RELEASE} hpw_hstate_t;

  hpw_hstate_t state_reg, state_next;
  logic [hpw_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  logic ready_reg, ready_next;
  logic mode_reg;
  logic cs_reg, wr_reg;
  logic [hpw_pkg::ADDR_W-1:0] addr_reg;
  logic fifo_reg;
  logic [hpw_pkg::DATA_W-1:0] data_reg;
  logic take;

  // ****************************************
  // Sequencing
  // ****************************************
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    take = 1'b0;
    case (state_reg)
      HPW_IDLE: begin
        if (req_valid && ready_reg) begin
          take = 1'b1;
          state_next = HPW_ASSERT;
          cnt_next = '0;
        end
      end
      HPW_ASSERT: begin
        if (cnt_reg == hpw_pkg::ASSERT_LAST) begin // RULE_06
          state_next = HPW_RELEASE;
          cnt_next = '0;
        end else begin
          cnt_next = cnt_reg + 1'b1;
        end
      end
      HPW_RELEASE: begin
        if (cnt_reg != hpw_pkg::RELEASE_LAST) begin // RULE_05
          cnt_next = cnt_reg + 1'b1;
        end else if (req_valid && ready_reg) begin // RULE_07
          take = 1'b1;
          state_next = HPW_ASSERT;
          cnt_next = '0;
        end else begin
          state_next = HPW_IDLE;
        end
      end
      default: begin
        state_next = HPW_IDLE;
        cnt_next = '0;
      end
    endcase
    ready_next = (state_next == HPW_IDLE) ||
                 (state_next == HPW_RELEASE && cnt_next == hpw_pkg::RELEASE_LAST);
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= HPW_IDLE;
      cnt_reg <= '0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  // ****************************************
  // Address, select and data hold
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      addr_reg <= hpw_pkg::ADDR_RST;
      fifo_reg <= 1'b0;
      data_reg <= hpw_pkg::DATA_RST;
      mode_reg <= 1'b0;
    end else if (take) begin
      addr_reg <= req_addr; // RULE_11
      fifo_reg <= req_fifo; // RULE_10
      data_reg <= req_data; // RULE_08
      mode_reg <= frame_by_cs;
    end
  end

  // ****************************************
  // Strobes
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cs_reg <= hpw_pkg::STROBE_IDLE;
      wr_reg <= hpw_pkg::STROBE_IDLE;
    end else if (state_next == HPW_ASSERT) begin
      cs_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else if (state_next == HPW_RELEASE) begin
      cs_reg <= mode_reg ? 1'b1 : 1'b0; // RULE_02
      wr_reg <= mode_reg ? 1'b0 : 1'b1;
    end else begin
      cs_reg <= hpw_pkg::STROBE_IDLE;
      wr_reg <= hpw_pkg::STROBE_IDLE;
    end
  end

  assign req_ready = ready_reg;
  assign link.chip_sel_low = cs_reg;
  assign link.write_strobe_low = wr_reg;
  assign link.addr = addr_reg;
  assign link.fifo_sel = fifo_reg;
  assign link.data = data_reg;
endmodule

//--- rtl/hpw_device.sv
// Device end: decodes write cycles into register writes or queue pushes
`timescale 1ns/100ps
module hpw_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 8
) (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wp_reg, rp_reg;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic full_reg, empty_reg;
  logic push, pop;

  assign push = in_valid && !full_reg;
  assign pop = out_ready && !empty_reg;

  always_comb begin
    cnt_next = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
      cnt_reg <= '0;
      full_reg <= 1'b0;
      empty_reg <= 1'b1;
    end else begin
      if (push) begin
        wp_reg <= (wp_reg == PW'(DEPTH - 1)) ? '0 : wp_reg + 1'b1;
      end
      if (pop) begin
        rp_reg <= (rp_reg == PW'(DEPTH - 1)) ? '0 : rp_reg + 1'b1;
      end
      cnt_reg <= cnt_next;
      full_reg <= (cnt_next == CW'(DEPTH));
      empty_reg <= (cnt_next == '0);
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem[wp_reg] <= in_data;
    end
  end

  assign in_ready = !full_reg;
  assign out_valid = !empty_reg;
  assign out_data = mem[rp_reg];
endmodule

module hpw_device (
  input wire logic core_clk,
  input wire logic rst,
  hpw_link_if.dev link,
  output logic reg_wr_valid,
  output logic [hpw_pkg::ADDR_W-1:0] reg_wr_addr,
  output logic [hpw_pkg::DATA_W-1:0] reg_wr_data,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [hpw_pkg::DATA_W-1:0] tx_data,
  output logic [hpw_pkg::LANE_W-1:0] tx_lane,
  output logic tx_space,
  output logic tx_drop
);
  typedef enum logic {HPW_WAIT, HPW_ACTIVE} hpw_dstate_t;

  localparam int QW = hpw_pkg::LANE_W + hpw_pkg::DATA_W;

  logic [hpw_pkg::SYNC_W-1:0] sync1_reg, sync2_reg;
  logic cs_low, wr_low, sel_s;
  logic [hpw_pkg::ADDR_W-1:0] addr_s;
  logic [hpw_pkg::DATA_W-1:0] data_s;
  logic both_low;
  hpw_dstate_t state_reg;
  logic [hpw_pkg::ADDR_W-1:0] cap_addr_reg;
  logic cap_sel_reg;
  logic [hpw_pkg::DATA_W-1:0] cap_data_reg;
  logic cycle_end;
  logic push_reg;
  logic [QW-1:0] push_data_reg;
  logic drop_reg;
  logic wr_valid_reg;
  logic [hpw_pkg::ADDR_W-1:0] wr_addr_reg;
  logic [hpw_pkg::DATA_W-1:0] wr_data_reg;
  logic q_in_ready, q_out_valid;
  logic [QW-1:0] q_out_data;

  // ****************************************
  // Pin synchronisers
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sync1_reg <= {2'b11, {(hpw_pkg::SYNC_W - 2){1'b0}}};
      sync2_reg <= {2'b11, {(hpw_pkg::SYNC_W - 2){1'b0}}};
    end else begin
      sync1_reg <= {link.chip_sel_low, link.write_strobe_low, link.fifo_sel, link.addr,
                    link.data}; // RULE_11
      sync2_reg <= sync1_reg;
    end
  end

  assign {cs_low, wr_low, sel_s, addr_s, data_s} = sync2_reg;
  assign both_low = !cs_low && !wr_low; // RULE_03
  assign cycle_end = (state_reg == HPW_ACTIVE) && !both_low; // RULE_04

  // ****************************************
  // Cycle tracking
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= HPW_WAIT;
    end else begin
      case (state_reg)
        HPW_WAIT: if (both_low) begin
          state_reg <= HPW_ACTIVE; // RULE_02
        end
        HPW_ACTIVE: if (!both_low) begin
          state_reg <= HPW_WAIT;
        end
        default: state_reg <= HPW_WAIT;
      endcase
    end
  end

  // Latest word seen while both strobes low
  always_ff @(posedge core_clk) begin
    if (rst) begin
      cap_addr_reg <= hpw_pkg::ADDR_RST;
      cap_sel_reg <= 1'b0;
      cap_data_reg <= hpw_pkg::DATA_RST;
    end else if (both_low) begin
      cap_addr_reg <= addr_s;
      cap_sel_reg <= sel_s;
      cap_data_reg <= data_s; // RULE_08
    end
  end

  // ****************************************
  // Decode at cycle end
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_valid_reg <= 1'b0;
      wr_addr_reg <= hpw_pkg::ADDR_RST;
      wr_data_reg <= hpw_pkg::DATA_RST;
      push_reg <= 1'b0;
      push_data_reg <= '0;
    end else begin
      wr_valid_reg <= cycle_end && !cap_sel_reg; // RULE_01
      push_reg <= cycle_end && cap_sel_reg; // RULE_09
      if (cycle_end && !cap_sel_reg) begin
        wr_addr_reg <= cap_addr_reg;
        wr_data_reg <= cap_data_reg; // RULE_13
      end
      if (cycle_end && cap_sel_reg) begin
        push_data_reg <= {cap_addr_reg[1:0], cap_data_reg}; // RULE_12
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      drop_reg <= 1'b0;
    end else begin
      drop_reg <= push_reg && !q_in_ready;
    end
  end

  // ****************************************
  // Transmit queue
  // ****************************************
  hpw_fifo #(
    .WIDTH(QW),
    .DEPTH(hpw_pkg::FIFO_DEPTH)
  ) u_queue (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(push_reg), // RULE_10
    .in_ready(q_in_ready),
    .in_data(push_data_reg),
    .out_valid(q_out_valid),
    .out_ready(tx_ready),
    .out_data(q_out_data)
  );

  assign reg_wr_valid = wr_valid_reg;
  assign reg_wr_addr = wr_addr_reg;
  assign reg_wr_data = wr_data_reg;
  assign tx_valid = q_out_valid;
  assign tx_data = q_out_data[hpw_pkg::DATA_W-1:0];
  assign tx_lane = q_out_data[QW-1:hpw_pkg::DATA_W];
  assign tx_space = q_in_ready;
  assign tx_drop = drop_reg;
endmodule

//--- tb/hpw_link_chk.sv
// Assertions on the write link between host and device ends
`timescale 1ns/100ps
module hpw_link_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic chip_sel_low,
  input wire logic write_strobe_low,
  input wire logic [hpw_pkg::ADDR_W-1:0] addr,
  input wire logic fifo_sel,
  input wire logic [hpw_pkg::DATA_W-1:0] data
);
  // ************
  // Link checks
  // ************
  logic both_low;
  logic both_prev;
  logic [3:0] since_rise;
  assign both_low = !chip_sel_low && !write_strobe_low;
  // Cycles since the last cycle start
  always_ff @(posedge core_clk) begin
    if (rst) begin
      both_prev <= 1'b0;
      since_rise <= 4'hf;
    end else begin
      both_prev <= both_low;
      if (both_low && !both_prev) begin
        since_rise <= 4'h1;
      end else if (since_rise != 4'hf) begin
        since_rise <= since_rise + 4'h1;
      end
    end
  end
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  rst_idle_a: assert property ($fell(rst) |-> chip_sel_low && write_strobe_low)
    else $error("strobes not idle after reset");
  strobe_pulse_a: assert property (both_low |=> !both_low)
    else $error("strobes held low too long");
  frame_one_a: assert property (both_low ##1 !both_low ##1 both_low |->
    $past(chip_sel_low) != $past(write_strobe_low))
    else $error("back to back cycle not framed by one strobe");
  idle_both_a: assert property (both_low ##1 !both_low [*2] |->
    chip_sel_low && write_strobe_low)
    else $error("link not idle after cycle");
  addr_hold_a: assert property (both_low |=> $stable(addr) && $stable(fifo_sel))
    else $error("address or select moved at cycle end");
  data_hold_a: assert property (both_low |=> $stable(data))
    else $error("data moved at cycle end");
  cycle_time_a: assert property (both_low && !both_prev |->
    since_rise >= 4'(hpw_pkg::CYCLE_CYC))
    else $error("write cycle shorter than minimum");
  addr_launch_a: assert property (!$stable({addr, fifo_sel, data}) |-> both_low)
    else $error("address or data changed outside a cycle start");
  cover property ($rose(both_low) && fifo_sel);
  cover property ($rose(both_low) && !fifo_sel);
  cover property (both_low ##1 !both_low ##1 both_low);
endmodule

//--- tb/testbench.sv
// Self-checking bench joining host and device ends
`timescale 1ns/100ps
module testbench;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic req_valid = 1'b0;
  logic req_fifo = 1'b0;
  logic frame_by_cs = 1'b0;
  logic tx_ready = 1'b0;
  logic [hpw_pkg::ADDR_W-1:0] req_addr = 7'h00;
  logic [hpw_pkg::DATA_W-1:0] req_data = 16'h0000;
  logic req_ready, reg_wr_valid, tx_valid, tx_space, tx_drop;
  logic [hpw_pkg::ADDR_W-1:0] reg_wr_addr;
  logic [hpw_pkg::DATA_W-1:0] reg_wr_data, tx_data;
  logic [hpw_pkg::LANE_W-1:0] tx_lane;
  int num_errors = 0;
  int cmp_count = 0;
  int drops = 0;
  int drop_exp = 0;
  int rdy_mode = 0;
  logic [22:0] reg_q[$];
  logic [17:0] tx_q[$];
  always #50 core_clk = ~core_clk;
  hpw_link_if i_hpw_link_if ();
  hpw_host i_hpw_host (.core_clk(core_clk), .rst(rst), .link(i_hpw_link_if),
    .req_valid(req_valid), .req_ready(req_ready), .req_addr(req_addr), .req_fifo(req_fifo),
    .req_data(req_data), .frame_by_cs(frame_by_cs));
  hpw_device i_hpw_device (.core_clk(core_clk), .rst(rst), .link(i_hpw_link_if),
    .reg_wr_valid(reg_wr_valid), .reg_wr_addr(reg_wr_addr), .reg_wr_data(reg_wr_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .tx_lane(tx_lane),
    .tx_space(tx_space), .tx_drop(tx_drop));
  hpw_link_chk i_hpw_link_chk (.core_clk(core_clk), .rst(rst),
    .chip_sel_low(i_hpw_link_if.chip_sel_low), .write_strobe_low(i_hpw_link_if.write_strobe_low),
    .addr(i_hpw_link_if.addr), .fifo_sel(i_hpw_link_if.fifo_sel), .data(i_hpw_link_if.data));
  // ****************
  // Shared tasks
  // ****************
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    cmp_word(nm, {31'h0, e}, {31'h0, g});
  endtask
  task automatic final_report();
    if (num_errors == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic send(input logic [6:0] a, input logic f, input logic [15:0] d, input logic fr);
    int n;
    @(negedge core_clk);
    req_valid = 1'b1;
    req_addr = a;
    req_fifo = f;
    req_data = d;
    frame_by_cs = fr;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    if (n >= 20) begin
      num_errors++;
      final_report();
    end
    if (!f) begin
      reg_q.push_back({a, d});
    end else if (tx_q.size() >= hpw_pkg::FIFO_DEPTH) begin
      drop_exp++;
    end else begin
      tx_q.push_back({a[1:0], d});
    end
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (tx_q.size() + reg_q.size() != 0 && n < 300) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      final_report();
    end
  endtask
  // ****************
  // Model compare
  // ****************
  always @(negedge core_clk) begin
    tx_ready <= (rdy_mode == 1) || (rdy_mode == 2 && $urandom_range(3) != 0);
  end
  always @(posedge core_clk) begin
    if (!rst && reg_wr_valid === 1'b1) begin
      cmp_bit("reg_pending", 1'b1, reg_q.size() > 0);
      if (reg_q.size() > 0) begin
        cmp_word("reg_write", {9'h0, reg_q.pop_front()}, {9'h0, reg_wr_addr, reg_wr_data});
      end
    end
    if (!rst && tx_valid === 1'b1 && tx_ready === 1'b1) begin
      cmp_bit("tx_pending", 1'b1, tx_q.size() > 0);
      if (tx_q.size() > 0) begin
        cmp_word("tx_word", {14'h0, tx_q.pop_front()}, {14'h0, tx_lane, tx_data});
      end
    end
    if (!rst && tx_drop === 1'b1) begin
      drops++;
    end
  end
  // ****************
  // Scenarios
  // ****************
  initial begin
    void'($urandom(79));
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    cmp_bit("tx_space", 1'b1, tx_space);
    cmp_bit("tx_valid", 1'b0, tx_valid);
    rdy_mode = 1;
    for (int m = 0; m < 4; m++) begin
      send(7'h7f, m[0], 16'ha5c3 ^ 16'(m), m[1]);
      send(7'h00, m[0], 16'h5a3c, m[1]);
      send(7'h7a, !m[0], 16'hffff, !m[1]);
    end
    drain();
    rdy_mode = 0;
    for (int k = 0; k < 10; k++) begin
      send({3'h5 ^ 3'(k), 4'(k)}, 1'b1, 16'(k * 16'h1111), 1'b1);
    end
    repeat (6) @(negedge core_clk);
    cmp_bit("tx_space", 1'b0, tx_space);
    cmp_word("drops", 32'(drop_exp), 32'(drops));
    rdy_mode = 1;
    drain();
    repeat (2) @(negedge core_clk);
    cmp_bit("tx_space", 1'b1, tx_space);
    rdy_mode = 2;
    repeat (40) send(7'($urandom), 1'($urandom), 16'($urandom), 1'($urandom));
    rdy_mode = 1;
    drain();
    cmp_word("drops", 32'(drop_exp), 32'(drops));
    final_report();
  end
endmodule
